// ### verilog/qdl_host_end.sv
module qdl_host_end #(
    parameter int CHAIN_LEN = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial link
    qdl_link_if.host link,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int TOTAL = CHAIN_LEN * qdl_pkg::WORD_BITS;
    localparam int BW = $clog2(TOTAL + 1);
    localparam int IW = (CHAIN_LEN > 1) ? $clog2(CHAIN_LEN) : 1;
    localparam logic [BW-1:0] LAST_BIT = BW'(TOTAL - 1);
    localparam logic [2:0] GAP_LAST = 3'(qdl_pkg::STROBE_GAP_TICKS - 1);

    typedef enum logic [2:0] {QDL_IDLE, QDL_LEAD, QDL_LOW, QDL_HIGH, QDL_TAIL, QDL_GAP} qdl_state_e;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    function automatic logic is_word(input logic [7:0] a);
        return (a >= qdl_pkg::REG_WORD0) && (a < qdl_pkg::REG_WORD0 + 8'(4 * CHAIN_LEN)) &&
               (a[1:0] == 2'h0);
    endfunction

    function automatic logic [IW-1:0] word_idx(input logic [7:0] a);
        logic [7:0] off;
        off = (a - qdl_pkg::REG_WORD0) >> 2;
        return off[IW-1:0];
    endfunction

    logic [15:0] words [CHAIN_LEN];
    logic [15:0] ret_word;
    logic clear_level;
    logic done;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_held;
    logic w_held;
    logic wr_fire;
    logic start;
    qdl_state_e state;

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready = ~w_held;
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
    // a go while busy is dropped, not queued
    assign start = wr_fire && (aw_addr == qdl_pkg::REG_CTRL) && w_strb[0] &&
                   w_data[qdl_pkg::CTRL_GO_BIT] && (state == QDL_IDLE);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= qdl_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (is_word(aw_addr) || aw_addr == qdl_pkg::REG_CTRL ||
                            aw_addr == qdl_pkg::REG_STATUS || aw_addr == qdl_pkg::REG_RETURN) ?
                           qdl_pkg::RESP_OKAY : qdl_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // words stay writable during a frame; that frame sees the new bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < CHAIN_LEN; i++) begin
                words[i] <= '0;
            end
        end else if (wr_fire && is_word(aw_addr)) begin
            if (w_strb[0]) begin
                words[word_idx(aw_addr)][7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                words[word_idx(aw_addr)][15:8] <= w_data[15:8];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clear_level <= 1'b0;
        end else if (wr_fire && aw_addr == qdl_pkg::REG_CTRL && w_strb[0]) begin
            clear_level <= w_data[qdl_pkg::CTRL_CLEAR_BIT];
        end
    end

    assign link.async_zero_n = ~clear_level;

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= qdl_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= qdl_pkg::RESP_OKAY;
            if (is_word(s_axi_araddr)) begin
                s_axi_rdata <= {16'h0000, words[word_idx(s_axi_araddr)]};
            end else if (s_axi_araddr == qdl_pkg::REG_CTRL) begin
                s_axi_rdata <= {30'h0, clear_level, 1'b0};
            end else if (s_axi_araddr == qdl_pkg::REG_STATUS) begin
                s_axi_rdata <= {30'h0, done, state != QDL_IDLE};
            end else if (s_axi_araddr == qdl_pkg::REG_RETURN) begin
                s_axi_rdata <= {16'h0000, ret_word};
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= qdl_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    logic tick;
    logic [BW-1:0] bit_idx;
    logic [2:0] gap;

    qdl_tick_div #(.PERIOD(qdl_pkg::SCK_HALF_CYC)) u_div (
        .clk(clk),
        .resetn(resetn),
        .tick(tick)
    );

    // word 0 goes first and so ends up in the farthest chain member
    function automatic logic pick_bit(input logic [BW-1:0] b);
        logic [BW-1:0] w;
        w = b >> 4;
        return words[w[IW-1:0]][4'hF - b[3:0]];
    endfunction

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= QDL_IDLE;
            link.sck <= 1'b0;
            link.sdi <= 1'b0;
            link.select_load_strobe_n <= 1'b1;
            bit_idx <= '0;
            gap <= '0;
        end else begin
            unique case (state)
                QDL_IDLE: begin
                    if (start) begin
                        link.select_load_strobe_n <= 1'b0;
                        link.sdi <= pick_bit('0);
                        bit_idx <= '0;
                        gap <= '0;
                        state <= QDL_LEAD;
                    end
                end
                QDL_LEAD: begin
                    if (tick) begin
                        gap <= gap + 3'h1;
                        if (gap == GAP_LAST) begin
                            link.sck <= 1'b1;
                            state <= QDL_HIGH;
                        end
                    end
                end
                QDL_HIGH: begin
                    if (tick) begin
                        link.sck <= 1'b0;
                        bit_idx <= bit_idx + BW'(1);
                        if (bit_idx == LAST_BIT) begin
                            state <= QDL_TAIL;
                        end else begin
                            link.sdi <= pick_bit(bit_idx + BW'(1));
                            state <= QDL_LOW;
                        end
                    end
                end
                QDL_LOW: begin
                    if (tick) begin
                        link.sck <= 1'b1;
                        state <= QDL_HIGH;
                    end
                end
                QDL_TAIL: begin
                    if (tick) begin
                        link.select_load_strobe_n <= 1'b1;
                        gap <= '0;
                        state <= QDL_GAP;
                    end
                end
                QDL_GAP: begin
                    if (tick) begin
                        gap <= gap + 3'h1;
                        if (gap == GAP_LAST) begin
                            state <= QDL_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // chain output sampled just before each rising sck
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ret_word <= '0;
        end else if (tick && (state == QDL_LOW || (state == QDL_LEAD && gap == GAP_LAST))) begin
            ret_word <= {ret_word[14:0], link.sdo};
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done <= 1'b0;
        end else if (state == QDL_GAP && tick && gap == GAP_LAST) begin
            done <= 1'b1;
        end else if (wr_fire && aw_addr == qdl_pkg::REG_STATUS && w_strb[0] &&
                     w_data[qdl_pkg::STAT_DONE_BIT]) begin
            done <= 1'b0;
        end
    end
endmodule // qdl_host_end

// ### verilog/qdl_pkg.sv
package qdl_pkg;
    // ------------------------------------------------------------
    // serial word layout
    // ------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 10;
    localparam int NUM_CH = 4;
    localparam int SEL_MSB = 15;
    localparam int SEL_LSB = 12;
    localparam int CODE_MSB = 11;
    localparam int CODE_LSB = 2;
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_CH_A = 4'h1;
    localparam logic [3:0] SEL_CH_D = 4'h4;
    localparam logic [3:0] SEL_SLEEP = 4'hE;
    localparam logic [3:0] SEL_ALL = 4'hF;
    localparam logic [9:0] CODE_ZERO = 10'h000;
    // ------------------------------------------------------------
    // host timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCK_HALF_NS = 64;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_GAP_NS = 100;
    localparam int STROBE_GAP_TICKS = (STROBE_GAP_NS + SCK_HALF_NS - 1) / SCK_HALF_NS;
    // ------------------------------------------------------------
    // host register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RETURN = 8'h08;
    localparam logic [7:0] REG_WORD0 = 8'h10;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : qdl_pkg

// ### verilog/qdl_link_if.sv
interface qdl_link_if;
    logic sck;
    logic sdi;
    logic select_load_strobe_n;
    logic async_zero_n;
    logic sdo;

    modport host (
        output sck,
        output sdi,
        output select_load_strobe_n,
        output async_zero_n,
        input sdo
    );

    modport dev (
        input sck,
        input sdi,
        input select_load_strobe_n,
        input async_zero_n,
        output sdo
    );
endinterface : qdl_link_if

// ### verilog/qdl_tick_div.sv
module qdl_tick_div #(
    parameter int PERIOD = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // enable pulse
    output logic tick
);
    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] count;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (count == LAST) begin
            count <= '0;
        end else begin
            count <= count + CW'(1);
        end
    end

    assign tick = (count == LAST);
endmodule // qdl_tick_div

// ### verilog/qdl_dev_end.sv
module qdl_dev_end (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial link
    qdl_link_if.dev link,
    // converter codes
    output logic [qdl_pkg::NUM_CH-1:0][qdl_pkg::CODE_BITS-1:0] channel_outputs,
    // sleep control
    output logic sleep_active,
    output logic ref_hiz,
    output logic outputs_hiz,
    // load observation
    output logic load_pulse,
    output logic [3:0] target_select_field,
    output logic [4:0] frame_bits,
    output logic short_frame
);
    // ------------------------------------------------------------
    // clear domain
    // ------------------------------------------------------------
    // power-up reset and the clear pin share one asynchronous net
    logic zero_n;

    assign zero_n = resetn & link.async_zero_n;

    // ------------------------------------------------------------
    // edge detection on the link pins
    // ------------------------------------------------------------
    logic sck_q;
    logic strobe_q;
    logic sck_rise;
    logic strobe_rise;

    // sck low at idle, so the first rise after the strobe falls is real
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= link.sck;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strobe_q <= 1'b1;
        end else begin
            strobe_q <= link.select_load_strobe_n;
        end
    end

    // shift only on sck rises inside a frame
    assign sck_rise = link.sck & ~sck_q & ~link.select_load_strobe_n;
    assign strobe_rise = link.select_load_strobe_n & ~strobe_q;

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    logic [qdl_pkg::WORD_BITS-1:0] shift_reg;

    always_ff @(posedge clk or negedge zero_n) begin
        if (!zero_n) begin
            shift_reg <= '0;
        end else if (sck_rise) begin
            shift_reg <= {shift_reg[qdl_pkg::WORD_BITS-2:0], link.sdi};
        end
    end

    // msb is the bit that entered sixteen rises ago
    assign link.sdo = shift_reg[qdl_pkg::WORD_BITS-1];

    // ------------------------------------------------------------
    // word fields
    // ------------------------------------------------------------
    logic [3:0] sel_field;
    logic [qdl_pkg::CODE_BITS-1:0] output_code_field;

    // tail bits below CODE_LSB are never looked at
    assign sel_field = shift_reg[qdl_pkg::SEL_MSB:qdl_pkg::SEL_LSB];
    assign output_code_field = shift_reg[qdl_pkg::CODE_MSB:qdl_pkg::CODE_LSB];

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic sel_hits(input logic [3:0] sel, input int ch);
        logic hit;
        hit = (sel == qdl_pkg::SEL_ALL) || (sel == qdl_pkg::SEL_CH_A + 4'(ch));
        return hit;
    endfunction

    function automatic logic sel_wakes(input logic [3:0] sel);
        logic wake;
        wake = (sel == qdl_pkg::SEL_NONE) || (sel == qdl_pkg::SEL_ALL) ||
               ((sel >= qdl_pkg::SEL_CH_A) && (sel <= qdl_pkg::SEL_CH_D));
        return wake;
    endfunction

    logic load_wakes;
    logic load_sleeps;

    assign load_wakes = strobe_rise & sel_wakes(sel_field);
    assign load_sleeps = strobe_rise & (sel_field == qdl_pkg::SEL_SLEEP);

    // ------------------------------------------------------------
    // converter code registers
    // ------------------------------------------------------------
    // each holds an unsigned code; the analog side scales it by 1/1024
    logic [qdl_pkg::CODE_BITS-1:0] code [qdl_pkg::NUM_CH];

    for (genvar ch = 0; ch < qdl_pkg::NUM_CH; ch++) begin : g_ch
        always_ff @(posedge clk or negedge zero_n) begin
            if (!zero_n) begin
                code[ch] <= qdl_pkg::CODE_ZERO;
            end else if (strobe_rise && sel_hits(sel_field, ch)) begin
                code[ch] <= output_code_field;
            end
        end

        // unwritten channels keep their code through sleep and wake
        assign channel_outputs[ch] = code[ch];
    end

    // ------------------------------------------------------------
    // sleep state
    // ------------------------------------------------------------
    // sleep is not cleared by the clear pin, only by power-up or a waking load
    logic sleep;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sleep <= 1'b0;
        end else if (load_sleeps) begin
            sleep <= 1'b1;
        end else if (load_wakes) begin
            sleep <= 1'b0;
        end
    end

    // reserved codes fall through both branches above
    assign sleep_active = sleep;
    assign ref_hiz = sleep;
    assign outputs_hiz = sleep;

    // ------------------------------------------------------------
    // frame observation
    // ------------------------------------------------------------
    logic [4:0] bit_count;

    // saturates; a frame shorter than a word still loads what it has
    always_ff @(posedge clk or negedge zero_n) begin
        if (!zero_n) begin
            bit_count <= '0;
        end else if (link.select_load_strobe_n) begin
            bit_count <= '0;
        end else if (sck_rise && (bit_count != 5'h1F)) begin
            bit_count <= bit_count + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge zero_n) begin
        if (!zero_n) begin
            frame_bits <= '0;
        end else if (strobe_rise) begin
            frame_bits <= bit_count;
        end
    end

    always_ff @(posedge clk or negedge zero_n) begin
        if (!zero_n) begin
            short_frame <= 1'b0;
        end else if (strobe_rise) begin
            short_frame <= (bit_count < 5'(qdl_pkg::WORD_BITS));
        end
    end

    always_ff @(posedge clk or negedge zero_n) begin
        if (!zero_n) begin
            target_select_field <= qdl_pkg::SEL_NONE;
        end else if (strobe_rise) begin
            target_select_field <= sel_field;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            load_pulse <= 1'b0;
        end else begin
            load_pulse <= strobe_rise;
        end
    end
endmodule // qdl_dev_end

// ### verification/qdl_link_properties.sv
module qdl_link_properties #(
    parameter int CHAIN_LEN = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial link
    input wire logic sck,
    input wire logic sdi,
    input wire logic select_load_strobe_n,
    input wire logic async_zero_n,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // link framing checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [7:0] rises;
    // rises counted per frame, cleared as the strobe falls
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rises <= 8'h00;
        end else if ($fell(select_load_strobe_n)) begin
            rises <= 8'h00;
        end else if ($rose(sck)) begin
            rises <= rises + 8'h01;
        end
    end
    sequence lead_in;
        (!sck)[*8];
    endsequence
    chk_sck_low_lead: assert property ($fell(select_load_strobe_n) |-> lead_in)
        else $error("sck not low at frame start");
    chk_first_edge: assert property ($fell(select_load_strobe_n) |-> ##[16:40] $rose(sck))
        else $error("no sck rise after strobe fall");
    chk_sck_gated: assert property ($rose(sck) |-> !select_load_strobe_n)
        else $error("sck rise with strobe high");
    chk_whole_word: assert property ($rose(select_load_strobe_n) |->
        !sck && rises == 8'(16 * CHAIN_LEN))
        else $error("frame length wrong at load");
    chk_half_period: assert property ($rose(sck) |-> ##16 $fell(sck))
        else $error("sck high time wrong");
    chk_sdi_held: assert property (sck && $past(sck) |-> $stable(sdi))
        else $error("sdi moved while sck high");
    // pin seen high one sample back; clear acts asynchronously, so its cycle is exempt
    chk_sdo_timing: assert property ($changed(sdo) |->
        ($past(sck) && !$past(sck, 2)) || !async_zero_n || !$past(async_zero_n))
        else $error("sdo moved off its shift slot");
    chk_strobe_gap: assert property ($rose(select_load_strobe_n) |-> select_load_strobe_n[*8])
        else $error("strobe high pulse too short");
endmodule // qdl_link_properties

// ### verification/test_quad_dac_serial_load_control.sv
module test_quad_dac_serial_load_control;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // bench state
    // ------------------------------------------------------------
    logic clk, resetn, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv, slp, rhz, ohz, sht;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdt;
    logic [3:0] wstrb, sel, exp_sel;
    logic [1:0] bresp, rresp, r;
    logic [3:0][9:0] codes;
    logic [4:0] fb;
    logic [9:0] exp_code [4];
    logic exp_sleep, lp;
    logic [15:0] prev;
    logic [31:0] d;
    int err_count, total_checks, loads, sends;
    qdl_link_if link();
    qdl_host_end #(.CHAIN_LEN(1)) qdl_host_end_inst (.clk(clk), .resetn(resetn), .link(link),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rry));
    qdl_dev_end qdl_dev_end_inst (.clk(clk), .resetn(resetn), .link(link), .channel_outputs(codes),
        .sleep_active(slp), .ref_hiz(rhz), .outputs_hiz(ohz), .load_pulse(lp),
        .target_select_field(sel), .frame_bits(fb), .short_frame(sht));
    qdl_link_properties #(.CHAIN_LEN(1)) qdl_link_properties_inst (.clk(clk), .resetn(resetn),
        .sck(link.sck), .sdi(link.sdi), .select_load_strobe_n(link.select_load_strobe_n),
        .async_zero_n(link.async_zero_n), .sdo(link.sdo));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // one load pulse expected per frame
    always @(posedge clk) begin
        if (!resetn) loads <= 0;
        else if (lp === 1'b1) loads <= loads + 1;
    end
    task automatic report_and_stop();
        if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic stall();
        err_count++;
        $display("[FAIL] wait expected answer seen timeout");
        report_and_stop();
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // readies are judged at the falling edge, where nothing moves
    task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
        logic ta, tw, tb;
        int n;
        @(posedge clk);
        awa <= a;
        wd <= dt;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 1000; n++) begin
            @(negedge clk);
            ta = awv && awr;
            tw = wv && wr_r;
            tb = bv;
            rs = bresp;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb === 1'b1) begin
                bry <= 1'b0;
                break;
            end
        end
        if (n == 1000) stall();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
        logic ta, tr;
        int n;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 1000; n++) begin
            @(negedge clk);
            ta = arv && arr;
            tr = rv;
            dt = rdt;
            rs = rresp;
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (tr === 1'b1) begin
                rry <= 1'b0;
                break;
            end
        end
        if (n == 1000) stall();
    endtask
    function automatic void model(input logic [15:0] w);
        logic [3:0] a = w[15:12];
        exp_sel = a;
        if (a >= 4'h1 && a <= 4'h4) exp_code[a - 4'h1] = w[11:2];
        if (a == 4'hF) foreach (exp_code[i]) exp_code[i] = w[11:2];
        if (a == 4'hE) exp_sleep = 1'b1;
        else if (a <= 4'h4 || a == 4'hF) exp_sleep = 1'b0;
    endfunction
    task automatic verify(input bit full);
        for (int i = 0; i < 4; i++) chk("code", 32'(exp_code[i]), 32'(codes[i]));
        chk("sleep", 32'(exp_sleep), 32'(slp));
        chk("ref_hiz", 32'(exp_sleep), 32'(rhz));
        chk("out_hiz", 32'(exp_sleep), 32'(ohz));
        if (full) begin
            chk("select", 32'(exp_sel), 32'(sel));
            chk("bits", 32'h10, 32'(fb));
            chk("short", 32'h0, 32'(sht));
        end
    endtask
    task automatic send(input logic [15:0] w);
        int n;
        wr(qdl_pkg::REG_WORD0, {16'h0000, w}, r);
        chk("bresp", 32'(qdl_pkg::RESP_OKAY), 32'(r));
        wr(qdl_pkg::REG_CTRL, 32'h1, r);
        for (n = 0; n < 400; n++) begin
            rd(qdl_pkg::REG_STATUS, d, r);
            if (d[qdl_pkg::STAT_DONE_BIT] === 1'b1) break;
        end
        if (n == 400) stall();
        wr(qdl_pkg::REG_STATUS, 32'h2, r);
        rd(qdl_pkg::REG_RETURN, d, r);
        chk("rresp", 32'(qdl_pkg::RESP_OKAY), 32'(r));
        chk("return", {16'h0000, prev}, d);
        prev = w;
        sends++;
        model(w);
        verify(1'b1);
        chk("loads", 32'(sends), 32'(loads));
    endtask
    initial begin
        {resetn, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
        wstrb = 4'hF;
        {err_count, total_checks, sends, prev, exp_sleep, exp_sel} = '0;
        foreach (exp_code[i]) exp_code[i] = '0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        verify(1'b0);
        void'($urandom(97));
        wr(8'h3C, 32'h1, r);
        chk("bresp", 32'(qdl_pkg::RESP_SLVERR), 32'(r));
        rd(8'h3C, d, r);
        chk("rresp", 32'(qdl_pkg::RESP_SLVERR), 32'(r));
        for (int i = 0; i < 16; i++) send({4'(i), 10'($urandom), 2'($urandom)});
        send({4'hF, 10'h3FF, 2'h3});
        send(16'hE000);
        send(16'hE3FF);
        // clear leaves sleep alone; shift register goes to zero too
        wr(qdl_pkg::REG_CTRL, 32'h2, r);
        repeat (40) @(posedge clk);
        wr(qdl_pkg::REG_CTRL, 32'h0, r);
        foreach (exp_code[i]) exp_code[i] = '0;
        prev = '0;
        verify(1'b0);
        send(16'h0000);
        repeat (24) send(16'($urandom));
        report_and_stop();
    end
endmodule // test_quad_dac_serial_load_control
